// ==== src/stx_serial_core.sv ====
// Serial transmitter with synchronous clock output, receiver and register file
//
// Function
// - No shift clock pulses during start bit or stop bit.
// - Last-bit clock enable decides clocking of the final data bit.
// - Polarity select sets idle clock level; phase select sets clock phase.
// - Shift clock inactive while idle, sending preamble or sending break.
// - Transmitter disabled puts clock and data pins in high impedance.
// - Clock options leave the receiver untouched.
// - Data register writes feed transmit buffer, reads return receive buffer.
// - Enable control layout bit 7 to 0; resets to zero.
// - Each interrupt enable gates its own flag sources.
// - Transmitter enabled routes shifter to data pin and clocks to clock pin.
// - Enable rising sends preamble of 10 or 11 ones by word length.
// - Enable cleared mid-byte finishes that byte before releasing pins.
// - Enable toggled mid-byte finishes byte then sends a fresh preamble.
// - After preamble, empty buffer holds line high; else transmission continues.
// - Stop state freezes baud generator and transmission; exit resumes it.
// - Receiver samples at sixteen times the baud rate.
`timescale 1ns/10ps
module stx_serial_core (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire stx_pkg::stx_bus_s bus,
    output logic [7:0] rdata,
    // Low power stop request
    input wire logic stop_mode,
    // Serial pins
    input wire logic rxd,
    output stx_pkg::stx_pins_s pins,
    // Interrupt
    output logic irq
);

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_PRE = 3'b100,
        TX_START = 3'b001,
        TX_DATA = 3'b011,
        TX_STOP = 3'b010,
        TX_BRK = 3'b110
    } stx_tx_e;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } stx_rx_e;

    typedef struct packed {
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [7:0] mask;
        logic [7:0] status;
        logic [7:0] baud;
        logic [7:0] rdata;
        logic irq;
        stx_tx_e tx_st;
        logic [3:0] tx_tick;
        logic [3:0] tx_bits;
        logic [8:0] tx_shift;
        logic [8:0] tx_buf;
        logic buf_empty;
        logic pre_req;
        stx_pkg::stx_pins_s pins;
        logic rx_meta;
        logic rx_sync;
        stx_rx_e rx_st;
        logic [3:0] rx_tick;
        logic [3:0] rx_bits;
        logic [8:0] rx_shift;
        logic [7:0] rx_buf;
        logic rx_unread;
        logic [7:0] idle_cnt;
        logic idle_armed;
    } stx_core_s;

    stx_core_s s_q;
    stx_core_s s_d;
    logic tick16;
    logic [7:0] ev;
    logic [7:0] gate;
    logic [3:0] tx_nbits;
    logic [3:0] rx_nbits;
    logic [3:0] pre_len;
    logic drive;
    logic active;

    // Stop state halts the shared sample tick, freezing both directions
    stx_baud_gen u_baud (
        .clk(clk),
        .resetn(resetn),
        .halt(stop_mode),
        .divisor(s_q.baud),
        .tick16(tick16)
    );

    // Next-state logic for registers, transmitter and receiver
    always_comb begin
        s_d = s_q;
        ev = 8'h00;
        tx_nbits = stx_pkg::stx_word_bits(s_q.ctl1[stx_pkg::C1_WL]);
        rx_nbits = stx_pkg::stx_word_bits(s_q.ctl1[stx_pkg::C1_WL]);
        pre_len = s_q.ctl1[stx_pkg::C1_WL] ? stx_pkg::PRE_BITS_LONG
                                           : stx_pkg::PRE_BITS_SHORT;
        drive = 1'b0;
        active = 1'b0;
        s_d.rx_meta = rxd;
        s_d.rx_sync = s_q.rx_meta;

        // Register reads: data answers one cycle after the strobe
        s_d.rdata = 8'h00;
        if (bus.rd) begin
            if (bus.addr == stx_pkg::ADDR_CTL1) begin
                s_d.rdata = s_q.ctl1;
            end else if (bus.addr == stx_pkg::ADDR_CTL2) begin
                s_d.rdata = s_q.ctl2;
            end else if (bus.addr == stx_pkg::ADDR_STATUS) begin
                s_d.rdata = s_q.status;
            end else if (bus.addr == stx_pkg::ADDR_DATA) begin
                s_d.rdata = s_q.rx_buf;
                s_d.rx_unread = 1'b0;
            end else if (bus.addr == stx_pkg::ADDR_MASK) begin
                s_d.rdata = s_q.mask;
            end else if (bus.addr == stx_pkg::ADDR_BAUD) begin
                s_d.rdata = s_q.baud;
            end
        end

        // Register writes; unmapped writes are dropped
        if (bus.wr) begin
            if (bus.addr == stx_pkg::ADDR_CTL1) begin
                s_d.ctl1 = bus.wdata;
            end else if (bus.addr == stx_pkg::ADDR_CTL2) begin
                s_d.ctl2 = bus.wdata;
                // A rising enable queues a preamble even mid-byte
                if (!s_q.ctl2[stx_pkg::C2_TE] && bus.wdata[stx_pkg::C2_TE]) begin
                    s_d.pre_req = 1'b1;
                end
            end else if (bus.addr == stx_pkg::ADDR_DATA) begin
                s_d.tx_buf = {s_q.ctl1[stx_pkg::C1_T8], bus.wdata};
                s_d.buf_empty = 1'b0;
            end else if (bus.addr == stx_pkg::ADDR_MASK) begin
                s_d.mask = bus.wdata & stx_pkg::ST_STICKY;
            end else if (bus.addr == stx_pkg::ADDR_BAUD) begin
                s_d.baud = bus.wdata;
            end
        end

        // Transmitter, one step per sample tick
        if (tick16) begin
            if (s_q.tx_st != TX_IDLE) begin
                s_d.tx_tick = s_q.tx_tick + 4'h1;
            end
            case (s_q.tx_st)
                TX_IDLE: begin
                    s_d.tx_tick = 4'h0;
                    s_d.tx_bits = 4'h0;
                    if (s_q.ctl2[stx_pkg::C2_TE]) begin
                        if (s_d.pre_req) begin
                            s_d.pre_req = 1'b0;
                            s_d.tx_st = TX_PRE;
                        end else if (s_q.ctl2[stx_pkg::C2_SBK]) begin
                            s_d.tx_st = TX_BRK;
                        end else if (!s_d.buf_empty) begin
                            s_d.tx_shift = s_d.tx_buf;
                            s_d.buf_empty = 1'b1;
                            ev[stx_pkg::ST_TX_EMPTY] = 1'b1;
                            s_d.tx_st = TX_START;
                        end
                    end
                end
                TX_PRE: begin
                    if (s_q.tx_tick == stx_pkg::TICK_LAST) begin
                        s_d.tx_bits = s_q.tx_bits + 4'h1;
                        if (s_q.tx_bits == pre_len - 4'h1) begin
                            s_d.tx_st = TX_IDLE;
                        end
                    end
                end
                TX_START: begin
                    if (s_q.tx_tick == stx_pkg::TICK_LAST) begin
                        s_d.tx_bits = 4'h0;
                        s_d.tx_st = TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (s_q.tx_tick == stx_pkg::TICK_LAST) begin
                        s_d.tx_shift = {1'b0, s_q.tx_shift[8:1]};
                        s_d.tx_bits = s_q.tx_bits + 4'h1;
                        if (s_q.tx_bits == tx_nbits - 4'h1) begin
                            s_d.tx_st = TX_STOP;
                        end
                    end
                end
                TX_STOP: begin
                    // Byte always completes, even with the enable dropped
                    if (s_q.tx_tick == stx_pkg::TICK_LAST) begin
                        s_d.tx_st = TX_IDLE;
                        if (s_d.buf_empty) begin
                            ev[stx_pkg::ST_TX_DONE] = 1'b1;
                        end
                    end
                end
                TX_BRK: begin
                    s_d.tx_tick = 4'h0;
                    if (!s_q.ctl2[stx_pkg::C2_SBK] || !s_q.ctl2[stx_pkg::C2_TE]) begin
                        s_d.tx_st = TX_IDLE;
                    end
                end
                default: begin
                    s_d.tx_st = TX_IDLE;
                end
            endcase
        end

        // Pin drive follows the enable, or a frame still finishing
        drive = s_q.ctl2[stx_pkg::C2_TE] || (s_q.tx_st != TX_IDLE);
        s_d.pins.tdo_oe_n = !drive;
        s_d.pins.sclk_oe_n = !drive;
        case (s_q.tx_st)
            TX_START: s_d.pins.tdo = 1'b0;
            TX_DATA: s_d.pins.tdo = s_q.tx_shift[0];
            TX_BRK: s_d.pins.tdo = 1'b0;
            default: s_d.pins.tdo = 1'b1;
        endcase

        // Shift clock only inside data bits; the options are not seen by the receiver
        if (s_q.tx_st == TX_DATA) begin
            active = s_q.ctl1[stx_pkg::C1_CLOCK_PHASE_SEL] ? (s_q.tx_tick < stx_pkg::TICK_HALF)
                                                : (s_q.tx_tick >= stx_pkg::TICK_HALF);
            if (s_q.tx_bits == tx_nbits - 4'h1 && !s_q.ctl1[stx_pkg::C1_LAST_BIT_CLOCK_EN]) begin
                active = 1'b0;
            end
        end
        // Released clock holds its level, so a polarity change shows no edge
        if (drive) begin
            s_d.pins.sclk = s_q.ctl1[stx_pkg::C1_CLOCK_POLARITY_SEL] ^ active;
        end

        // Receiver, sixteen samples per bit, centre sample taken
        if (!s_q.ctl2[stx_pkg::C2_RE]) begin
            s_d.rx_st = RX_IDLE;
            s_d.rx_tick = 4'h0;
        end else if (tick16) begin
            s_d.rx_tick = s_q.rx_tick + 4'h1;
            case (s_q.rx_st)
                RX_IDLE: begin
                    s_d.rx_tick = 4'h0;
                    if (!s_q.rx_sync) begin
                        s_d.rx_st = RX_START;
                        s_d.idle_cnt = 8'h00;
                    end else if (s_q.idle_cnt != stx_pkg::IDLE_TICKS) begin
                        s_d.idle_cnt = s_q.idle_cnt + 8'h01;
                    end else if (s_q.idle_armed) begin
                        s_d.idle_armed = 1'b0;
                        ev[stx_pkg::ST_IDLE] = 1'b1;
                    end
                end
                RX_START: begin
                    // False start if the line is high again at mid bit
                    if (s_q.rx_tick == stx_pkg::TICK_MID) begin
                        s_d.rx_tick = 4'h0;
                        s_d.rx_bits = 4'h0;
                        s_d.rx_st = s_q.rx_sync ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (s_q.rx_tick == stx_pkg::TICK_LAST) begin
                        s_d.rx_shift = {s_q.rx_sync, s_q.rx_shift[8:1]};
                        s_d.rx_bits = s_q.rx_bits + 4'h1;
                        if (s_q.rx_bits == rx_nbits - 4'h1) begin
                            s_d.rx_st = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (s_q.rx_tick == stx_pkg::TICK_LAST) begin
                        s_d.rx_st = RX_IDLE;
                        s_d.idle_cnt = 8'h00;
                        s_d.idle_armed = 1'b1;
                        // Wake-up mode discards characters until an idle line
                        if (s_q.rx_sync && !s_q.ctl2[stx_pkg::C2_RWU]) begin
                            if (s_q.rx_unread) begin
                                ev[stx_pkg::ST_OVERRUN] = 1'b1;
                            end else begin
                                s_d.rx_buf = s_q.ctl1[stx_pkg::C1_WL] ? s_q.rx_shift[7:0]
                                                                      : s_q.rx_shift[8:1];
                                s_d.rx_unread = 1'b1;
                                ev[stx_pkg::ST_RX_FULL] = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    s_d.rx_st = RX_IDLE;
                end
            endcase
        end
        if (ev[stx_pkg::ST_IDLE]) begin
            s_d.ctl2[stx_pkg::C2_RWU] = 1'b0;
        end

        // Sticky flags: read clears, a same-cycle event still wins
        if (bus.rd && bus.addr == stx_pkg::ADDR_STATUS) begin
            s_d.status = s_q.status & ~stx_pkg::ST_STICKY;
        end
        s_d.status = (s_d.status | ev) & stx_pkg::ST_STICKY;
        s_d.status[stx_pkg::ST_BUF_LEVEL] = s_d.buf_empty;

        // Each enable gates its own sources, then the mask
        gate = 8'h00;
        gate[stx_pkg::ST_TX_EMPTY] = s_q.ctl2[stx_pkg::C2_TIE];
        gate[stx_pkg::ST_TX_DONE] = s_q.ctl2[stx_pkg::C2_TX_DONE_IRQ_EN];
        gate[stx_pkg::ST_RX_FULL] = s_q.ctl2[stx_pkg::C2_RIE];
        gate[stx_pkg::ST_OVERRUN] = s_q.ctl2[stx_pkg::C2_RIE];
        gate[stx_pkg::ST_IDLE] = s_q.ctl2[stx_pkg::C2_IDLE_IRQ_EN];
        s_d.irq = |(s_d.status & s_q.mask & gate);
    end

    // State register; control clears to zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.ctl1 <= stx_pkg::CTL1_RST;
            s_q.ctl2 <= stx_pkg::CTL2_RST;
            s_q.mask <= stx_pkg::MASK_RST;
            s_q.status <= stx_pkg::STATUS_RST;
            s_q.baud <= stx_pkg::BAUD_RST;
            s_q.buf_empty <= 1'b1;
            s_q.rx_meta <= 1'b1;
            s_q.rx_sync <= 1'b1;
            s_q.pins <= '{tdo: 1'b1, tdo_oe_n: 1'b1, sclk: 1'b0, sclk_oe_n: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign rdata = s_q.rdata;
    assign pins = s_q.pins;
    assign irq = s_q.irq;

endmodule : stx_serial_core

// ==== common/stx_pkg.sv ====
// Shared constants, field layouts and carrier structs for the serial transmitter block
package stx_pkg;

    // Register offsets on the 8-bit register port
    localparam logic [7:0] ADDR_CTL1 = 8'h0E;
    localparam logic [7:0] ADDR_CTL2 = 8'h0F;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_DATA = 8'h11;
    localparam logic [7:0] ADDR_MASK = 8'h12;
    localparam logic [7:0] ADDR_BAUD = 8'h13;

    // Field positions of serial_control_one
    localparam int C1_LAST_BIT_CLOCK_EN = 0;
    localparam int C1_CLOCK_PHASE_SEL = 1;
    localparam int C1_CLOCK_POLARITY_SEL = 2;
    localparam int C1_WL = 4;
    localparam int C1_T8 = 6;

    // Field positions of serial_enable_control
    localparam int C2_SBK = 0;
    localparam int C2_RWU = 1;
    localparam int C2_RE = 2;
    localparam int C2_TE = 3;
    localparam int C2_IDLE_IRQ_EN = 4;
    localparam int C2_RIE = 5;
    localparam int C2_TX_DONE_IRQ_EN = 6;
    localparam int C2_TIE = 7;

    // Field positions of the status and mask registers
    localparam int ST_TX_EMPTY = 7;
    localparam int ST_TX_DONE = 6;
    localparam int ST_RX_FULL = 5;
    localparam int ST_IDLE = 4;
    localparam int ST_OVERRUN = 3;
    localparam int ST_BUF_LEVEL = 0;
    localparam logic [7:0] ST_STICKY = 8'hF8;

    // Reset values
    localparam logic [7:0] CTL1_RST = 8'h00;
    localparam logic [7:0] CTL2_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h01;
    localparam logic [7:0] BAUD_RST = 8'h0B;

    // Timing counts in sample ticks and bits
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] TICK_HALF = 4'h8;
    localparam logic [3:0] PRE_BITS_SHORT = 4'hA;
    localparam logic [3:0] PRE_BITS_LONG = 4'hB;
    localparam logic [3:0] BITS_SHORT = 4'h8;
    localparam logic [3:0] BITS_LONG = 4'h9;
    localparam logic [7:0] IDLE_TICKS = 8'h9F;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } stx_bus_s;

    // Transmit pins, enables active low
    typedef struct packed {
        logic tdo;
        logic tdo_oe_n;
        logic sclk;
        logic sclk_oe_n;
    } stx_pins_s;

    // Data bits per character from the word-length select
    function automatic logic [3:0] stx_word_bits(input logic long_word);
        stx_word_bits = long_word ? BITS_LONG : BITS_SHORT;
    endfunction : stx_word_bits

endpackage : stx_pkg

// ==== src/stx_baud_gen.sv ====
// Baud generator producing the sixteen-times sample tick enable
`timescale 1ns/10ps
module stx_baud_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic halt,
    input wire logic [7:0] divisor,
    // Tick enable
    output logic tick16
);

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } stx_baud_s;

    stx_baud_s s_q;
    stx_baud_s s_d;

    // Halt freezes the count so a stopped frame resumes where it left off
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!halt) begin
            if (s_q.cnt >= divisor) begin
                s_d.cnt = 8'h00;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick16 = s_q.tick;

endmodule : stx_baud_gen

// ==== tb/stx_peer.sv ====
// Shift-register peripheral on the transmit pins, with the line looped back to the receiver
`timescale 1ns/10ps
module stx_peer (
    // Clock
    input wire logic clk,
    // Transmit pins and the clock options the peripheral expects
    input wire stx_pkg::stx_pins_s pins,
    input wire logic clock_polarity_sel,
    input wire logic clock_phase_sel,
    // Captured bits, pulse count and looped-back line
    output logic [15:0] shift_q,
    output logic [7:0] pulses_q,
    output logic rxd
);
    logic act_q = 1'b0;
    logic act;

    // Released line floats to the pull-up level
    assign rxd = pins.tdo_oe_n ? 1'b1 : pins.tdo;
    assign act = (pins.sclk ^ clock_polarity_sel) && !pins.sclk_oe_n;

    // Leading edge samples in phase 0, trailing edge in phase 1
    initial pulses_q = 8'h00;
    always @(posedge clk) begin
        act_q <= act;
        if (act && !act_q) begin
            pulses_q <= pulses_q + 8'h01;
        end
        if (act != act_q && act_q == clock_phase_sel) begin
            shift_q <= {pins.tdo, shift_q[15:1]};
        end
    end
endmodule : stx_peer

// ==== tb/stx_chk.sv ====
// Concurrent checks on the register port and transmit pins
`timescale 1ns/10ps
module stx_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire stx_pkg::stx_bus_s bus,
    input wire logic [7:0] rdata,
    // Stop, receive, pins and interrupt
    input wire logic stop_mode,
    input wire logic rxd,
    input wire stx_pkg::stx_pins_s pins,
    input wire logic irq
);
    logic [7:0] ctl1_q;
    logic [7:0] ctl2_q;
    logic te_wr;

    // Mirrors of control writes; wake-up bit may self-clear, so it is masked
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl1_q <= 8'h00;
            ctl2_q <= 8'h00;
        end else if (bus.wr && bus.addr == stx_pkg::ADDR_CTL1) begin
            ctl1_q <= bus.wdata;
        end else if (bus.wr && bus.addr == stx_pkg::ADDR_CTL2) begin
            ctl2_q <= bus.wdata;
        end
    end
    assign te_wr = bus.wr && bus.addr == stx_pkg::ADDR_CTL2 && bus.wdata[3];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_RESET_PINS: assert property ($rose(resetn) |-> pins.tdo_oe_n && pins.sclk_oe_n && !irq)
        else $error("pins driven or irq high after reset");
    AST_OE_PAIR: assert property (pins.tdo_oe_n == pins.sclk_oe_n)
        else $error("data and clock enables differ");
    AST_RDATA_IDLE: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data outside its cycle");
    AST_CTL2_READBACK: assert property (bus.rd && bus.addr == stx_pkg::ADDR_CTL2 |=>
        (rdata & 8'hFD) == ($past(ctl2_q) & 8'hFD)) else $error("enable control readback");
    AST_UNMAPPED_ZERO: assert property (bus.rd && bus.addr > stx_pkg::ADDR_BAUD |=>
        rdata == 8'h00) else $error("unmapped read not zero");
    AST_IRQ_GATED: assert property (irq |-> ctl2_q[7:4] != 4'h0 || $past(ctl2_q[7:4]) != 4'h0)
        else $error("irq with all enables clear");
    AST_STAY_RELEASED: assert property (pins.tdo_oe_n && !ctl2_q[3] && !te_wr |=>
        pins.tdo_oe_n) else $error("pins driven while disabled");
    AST_RELEASE_DISABLED: assert property ($rose(pins.tdo_oe_n) |-> !$past(ctl2_q[3]))
        else $error("pins released while enabled");
    AST_PREAMBLE_QUIET: assert property ($fell(pins.tdo_oe_n) |->
        (pins.tdo && pins.sclk == ctl1_q[2])[*8]) else $error("preamble not quiet ones");
    AST_RELEASED_QUIET: assert property (pins.sclk_oe_n && $past(pins.sclk_oe_n) |->
        $stable(pins.sclk)) else $error("clock moves while released");

    // Main scenarios
    COV_PREAMBLE: cover property ($fell(pins.tdo_oe_n));
    COV_IRQ: cover property ($rose(irq));
    COV_START: cover property (!pins.tdo_oe_n && $fell(pins.tdo));
    COV_STOP: cover property (stop_mode && !pins.tdo_oe_n);
endmodule : stx_chk

bind stx_serial_core stx_chk u_chk (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
    .stop_mode(stop_mode), .rxd(rxd), .pins(pins), .irq(irq));

// ==== tb/test_stx_serial_core.sv ====
// Self-checking bench: register access, synchronous frames, interrupts, break, stop
`timescale 1ns/10ps
module test_stx_serial_core;
    logic clk;
    logic resetn;
    stx_pkg::stx_bus_s bus;
    logic [7:0] rdata;
    logic stop_mode;
    logic rxd;
    stx_pkg::stx_pins_s pins;
    stx_pkg::stx_pins_s snap;
    logic irq;
    logic clock_polarity_sel;
    logic clock_phase_sel;
    logic last_bit_clock_en;
    logic [15:0] shift_q;
    logic [7:0] pulses_q;
    logic [7:0] p0;
    logic [7:0] rv;
    logic [8:0] full;
    int n_errors;
    int cmp_count;
    int n;
    int nb;
    int p;

    stx_serial_core uut (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
        .stop_mode(stop_mode), .rxd(rxd), .pins(pins), .irq(irq));
    stx_peer peer (.clk(clk), .pins(pins), .clock_polarity_sel(clock_polarity_sel), .clock_phase_sel(clock_phase_sel), .shift_q(shift_q),
        .pulses_q(pulses_q), .rxd(rxd));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One-cycle strobes; the idle cycle after each keeps drivers apart
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) bus <= {a, d, 2'b10};
        @(posedge clk) bus <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) bus <= {a, 8'h00, 2'b01};
        @(posedge clk) bus <= '0;
        #1 d = rdata;
    endtask : rd

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : tick

    // Bounded wait for the start bit
    task automatic wait_fall(output int cyc);
        cyc = 0;
        while (pins.tdo !== 1'b0 && cyc < 400) begin
            tick(1);
            cyc++;
        end
    endtask : wait_fall

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up();
    end

    initial begin
        resetn = 1'b0;
        bus = '0;
        stop_mode = 1'b0;
        clock_polarity_sel = 1'b0;
        clock_phase_sel = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        // Reset state, readback, unmapped place
        rd(stx_pkg::ADDR_CTL2, rv);
        check("ctl2 reset", rv, 8'h00);
        check("pins released", {pins.tdo_oe_n, pins.sclk_oe_n}, 2'b11);
        wr(stx_pkg::ADDR_CTL2, 8'hF4);
        rd(stx_pkg::ADDR_CTL2, rv);
        check("ctl2 readback", rv, 8'hF4);
        rd(8'h30, rv);
        check("unmapped", rv, 8'h00);
        wr(stx_pkg::ADDR_CTL2, 8'h00);
        wr(stx_pkg::ADDR_BAUD, 8'h00);
        // Every polarity and phase, both last-bit settings, both word lengths
        for (int k = 0; k < 4; k++) begin
            clock_polarity_sel = k[0];
            clock_phase_sel = k[1];
            last_bit_clock_en = !k[0];
            nb = (k == 3) ? 9 : 8;
            p = last_bit_clock_en ? nb : nb - 1;
            full = {1'b1, 8'hA5 ^ 8'(k)};
            wr(stx_pkg::ADDR_CTL1, {3'b010, k == 3, 1'b0, clock_polarity_sel, clock_phase_sel, last_bit_clock_en});
            wr(stx_pkg::ADDR_CTL2, 8'h0C);
            wr(stx_pkg::ADDR_DATA, full[7:0]);
            p0 = pulses_q;
            wait_fall(n);
            check("preamble", n >= (nb + 2) * 16 - 4 && n <= (nb + 2) * 16 + 6, 1'b1);
            check("no preamble clock", pulses_q - p0, 8'h00);
            check("clock idle level", pins.sclk, clock_polarity_sel);
            tick(40);
            wr(stx_pkg::ADDR_CTL2, 8'h04);
            if (k[0]) begin
                wr(stx_pkg::ADDR_CTL2, 8'h0C);
            end
            tick(8);
            check("byte continues", pins.tdo_oe_n, 1'b0);
            tick((nb + 2) * 16 - 44);
            check("pulses", pulses_q - p0, 8'(p));
            check("bits", shift_q >> (16 - p), 16'(full) & ((16'h1 << p) - 1));
            if (k[0]) begin
                tick((nb + 2) * 16 + 8);
                check("idle high driven", {pins.tdo, pins.tdo_oe_n}, 2'b10);
                check("no idle clock", pulses_q - p0, 8'(p));
            end else begin
                check("released after byte", pins.tdo_oe_n, 1'b1);
            end
            rd(stx_pkg::ADDR_DATA, rv);
            check("loopback", rv, full[7:0]);
            wr(stx_pkg::ADDR_CTL2, 8'h00);
            tick(40);
        end
        // Stop state mid-frame, then interrupt gating and masking
        clock_polarity_sel = 1'b0;
        clock_phase_sel = 1'b0;
        wr(stx_pkg::ADDR_CTL1, 8'h01);
        wr(stx_pkg::ADDR_MASK, 8'hF8);
        rd(stx_pkg::ADDR_STATUS, rv);
        wr(stx_pkg::ADDR_CTL2, 8'h0C);
        wr(stx_pkg::ADDR_DATA, 8'h3C);
        p0 = pulses_q;
        wait_fall(n);
        tick(40);
        @(posedge clk) stop_mode <= 1'b1;
        tick(3);
        snap = pins;
        tick(100);
        check("frozen", pins, snap);
        @(posedge clk) stop_mode <= 1'b0;
        tick(150);
        check("resumed pulses", pulses_q - p0, 8'h08);
        check("resumed bits", shift_q[15:8], 8'h3C);
        check("irq gated off", irq, 1'b0);
        wr(stx_pkg::ADDR_CTL2, 8'h4C);
        tick(3);
        check("done irq", irq, 1'b1);
        wr(stx_pkg::ADDR_MASK, 8'h00);
        tick(3);
        check("masked irq", irq, 1'b0);
        wr(stx_pkg::ADDR_MASK, 8'hF8);
        wr(stx_pkg::ADDR_CTL2, 8'h2C);
        tick(3);
        check("rx irq", irq, 1'b1);
        rd(stx_pkg::ADDR_STATUS, rv);
        check("status events", rv[6:5], 2'b11);
        tick(3);
        check("irq cleared", irq, 1'b0);
        // Break drives zeros without clock
        wr(stx_pkg::ADDR_CTL2, 8'h0D);
        p0 = pulses_q;
        tick(40);
        check("break low", pins.tdo, 1'b0);
        check("break no clock", pulses_q - p0, 8'h00);
        wr(stx_pkg::ADDR_CTL2, 8'h0C);
        tick(40);
        check("break ends", pins.tdo, 1'b1);
        wr(stx_pkg::ADDR_CTL2, 8'h00);
        tick(40);
        check("disabled", {pins.tdo_oe_n, pins.sclk_oe_n}, 2'b11);
        wrap_up();
    end
endmodule : test_stx_serial_core
